// *** sbst_pkg.sv ***
// Package: constants and types for the memory boundary-scan test port
package sbst_pkg;
	localparam int IR_W   = 3;    // Instruction register width
	localparam int ID_W   = 32;   // Identification register width
	localparam int BSC_N  = 107;  // Boundary chain length
	localparam int OE_CELL = 47;  // Output-enable cell position
	// Opcodes
	localparam logic [2:0] OP_EXT     = 3'h0;
	localparam logic [2:0] OP_IDENT   = 3'h1;
	localparam logic [2:0] OP_SNAPZ   = 3'h2;
	localparam logic [2:0] OP_SAMPLE  = 3'h4;
	localparam logic [2:0] OP_BYPASS  = 3'h7;
	// Identification fields (values arbitrary, not a real part)
	localparam logic [2:0]  ID_VERSION = 3'h2;
	localparam logic [16:0] ID_PART    = 17'h0a5a5;
	localparam logic [10:0] ID_MAKER   = 11'h2a5;
	localparam logic        ID_PRESENT = 1'b1;
	// Field positions
	localparam int ID_VER_LSB  = 29;
	localparam int ID_PART_LSB = 12;
	localparam int ID_MAK_LSB  = 1;
	// Reset values
	localparam logic [2:0] IR_RST  = OP_IDENT;
	localparam logic       OE_RST  = 1'b1;
	// Test clock period in ns and resulting samples per half period
	localparam int TCK_NS  = 400;
	localparam int CLK_NS  = 50;
	localparam int TCK_HALF_CYC = (TCK_NS / 2) / CLK_NS;
	// Controller states, one-hot
	typedef enum logic [15:0] {
		ST_RESET = 16'h0001, ST_IDLE  = 16'h0002, ST_SELDR = 16'h0004,
		ST_CAPDR = 16'h0008, ST_SHDR  = 16'h0010, ST_EX1DR = 16'h0020,
		ST_PSDR  = 16'h0040, ST_EX2DR = 16'h0080, ST_UPDR  = 16'h0100,
		ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR  = 16'h0800,
		ST_EX1IR = 16'h1000, ST_PSIR  = 16'h2000, ST_EX2IR = 16'h4000,
		ST_UPIR  = 16'h8000
	} sbst_state_t;
endpackage

// *** sbst_sync.sv ***
// Two-flop synchroniser for one pin input
module sbst_sync (
	input  wire logic mclk_in,   // Block clock
	input  wire logic rst_b_in,  // Synchronous reset, low
	input  wire logic pin_in,    // Asynchronous pin
	output logic      sync_out   // Synchronised level
);
	typedef struct packed {
		logic s1; // First stage, read by second only
		logic s2; // Second stage
	} sbst_sync_t;
	sbst_sync_t st;
	sbst_sync_t next_st;

	// Shift pin through two stages
	always_comb begin
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
		if (!rst_b_in) begin
			next_st = '0;
		end
	end

	// Register stages
	always_ff @(posedge mclk_in) begin
		st <= next_st;
	end

	assign sync_out = st.s2;
endmodule

// *** sbst_tap.sv ***
// Boundary-scan test access port of the burst memory
// Overview of operation
// - IR 3, bypass 1, ID 32, chain 107
// - Code 000: external test, chain selected
// - Code 001: load ID, ID selected
// - Code 010: sample, chain, outputs floated
// - Code 100: sample/preload, chain, no effect
// - Code 111: bypass bit selected
// - ID 31:29 version, 28:12 part code
// - ID 11:1 maker code
// - ID bit 0 reads one
// - Serial output changes after falling edge
// - ID instruction at reset and Test-Logic-Reset
// - Cell 47 output-enable under external test
// - Enable latch preset high on reset
// - External test drives preloaded cells out
module sbst_tap
	import sbst_pkg::*;
#(
	parameter int CHAIN_N = sbst_pkg::BSC_N  // Boundary chain length
) (
	input  wire logic               mclk_in,       // 20 MHz block clock
	input  wire logic               rst_b_in,      // Synchronous reset, low
	input  wire logic               tck_in,        // Test clock pin
	input  wire logic               tms_in,        // Mode select pin
	input  wire logic               tdi_in,        // Serial data in pin
	output logic                    tdo_out,       // Serial data out
	output logic                    tdo_oe_b_out,  // Low while tdo driven
	input  wire logic [CHAIN_N-1:0] pins_in,       // Pin ring capture
	output logic      [CHAIN_N-1:0] pins_drv_out,  // Preloaded values to pins
	output logic                    ext_mode_out,  // Pins take test values
	output logic                    q_float_out,   // Float memory outputs
	output logic [sbst_pkg::IR_W-1:0] ir_out       // Active instruction
);
	import sbst_pkg::*;

	// Whole state of the port
	typedef struct packed {
		logic              tck_d;   // Previous sampled test clock
		sbst_state_t       tap;     // Controller state
		logic [IR_W-1:0]   ir_sh;   // Instruction shift stage
		logic [IR_W-1:0]   ir;      // Active instruction
		logic              byp;     // Bypass bit
		logic [ID_W-1:0]   id_sh;   // Identification shift stage
		logic [CHAIN_N-1:0] bs_sh;  // Boundary shift stage
		logic [CHAIN_N-1:0] bs_up;  // Boundary update latches
		logic              tdo;     // Serial output
		logic              tdo_oe_b; // Output enable, low = drive
		logic              ext;     // External test mode
		logic              flt;     // Output float
	} sbst_tap_t;

	sbst_tap_t st;
	sbst_tap_t next_st;

	logic tck_s;  // Synchronised test clock
	logic tms_s;  // Synchronised mode select
	logic tdi_s;  // Synchronised data in
	logic rise;   // Test clock rising edge
	logic fall;   // Test clock falling edge
	logic sdo;    // Selected serial bit
	logic [ID_W-1:0] id_val; // Fixed identification word
	logic [CHAIN_N-1:0] ring_mix; // Ring with enable cell forced
	logic [CHAIN_N-1:0] pins_s;   // Synchronised pin ring

	// Pin synchronisers
	sbst_sync u_sync_tck (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .pin_in(tck_in),
		.sync_out(tck_s));
	sbst_sync u_sync_tms (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .pin_in(tms_in),
		.sync_out(tms_s));
	sbst_sync u_sync_tdi (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .pin_in(tdi_in),
		.sync_out(tdi_s));

	// Pin ring comes from the memory clock: two flops per cell before capture
	for (genvar g = 0; g < CHAIN_N; g++) begin : g_ring_sync
		sbst_sync u_sync_ring (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .pin_in(pins_in[g]),
			.sync_out(pins_s[g]));
	end

	// Edge detection on synchronised clock
	assign rise = tck_s & ~st.tck_d;
	assign fall = ~tck_s & st.tck_d;

	// Identification word assembly
	always_comb begin
		id_val = '0;
		id_val[ID_VER_LSB +: 3]   = ID_VERSION;
		id_val[ID_PART_LSB +: 17] = ID_PART;
		id_val[ID_MAK_LSB +: 11]  = ID_MAKER;
		id_val[0] = ID_PRESENT;
	end

	// Captured ring: enable cell is internal, captures its latch
	always_comb begin
		ring_mix = pins_s;
		ring_mix[OE_CELL] = st.bs_up[OE_CELL];
	end

	// Serial output select by instruction and state
	always_comb begin
		sdo = st.byp;
		if (st.tap == ST_SHIR) begin
			sdo = st.ir_sh[0];
		end else begin
			unique case (st.ir)
				OP_EXT: sdo = st.bs_sh[0];
				OP_IDENT: sdo = st.id_sh[0];
				OP_SNAPZ: sdo = st.bs_sh[0];
				OP_SAMPLE: sdo = st.bs_sh[0];
				OP_BYPASS: sdo = st.byp;
				// Reserved codes fall back to bypass
				default: sdo = st.byp;
			endcase
		end
	end

	// Next state of the whole port
	always_comb begin
		next_st = st;
		next_st.tck_d = tck_s;
		if (rise) begin
			unique case (st.tap)
				ST_RESET: next_st.tap = tms_s ? ST_RESET : ST_IDLE;
				ST_IDLE:  next_st.tap = tms_s ? ST_SELDR : ST_IDLE;
				ST_SELDR: next_st.tap = tms_s ? ST_SELIR : ST_CAPDR;
				ST_CAPDR: next_st.tap = tms_s ? ST_EX1DR : ST_SHDR;
				ST_SHDR:  next_st.tap = tms_s ? ST_EX1DR : ST_SHDR;
				ST_EX1DR: next_st.tap = tms_s ? ST_UPDR  : ST_PSDR;
				ST_PSDR:  next_st.tap = tms_s ? ST_EX2DR : ST_PSDR;
				ST_EX2DR: next_st.tap = tms_s ? ST_UPDR  : ST_SHDR;
				ST_UPDR:  next_st.tap = tms_s ? ST_SELDR : ST_IDLE;
				ST_SELIR: next_st.tap = tms_s ? ST_RESET : ST_CAPIR;
				ST_CAPIR: next_st.tap = tms_s ? ST_EX1IR : ST_SHIR;
				ST_SHIR:  next_st.tap = tms_s ? ST_EX1IR : ST_SHIR;
				ST_EX1IR: next_st.tap = tms_s ? ST_UPIR  : ST_PSIR;
				ST_PSIR:  next_st.tap = tms_s ? ST_EX2IR : ST_PSIR;
				ST_EX2IR: next_st.tap = tms_s ? ST_UPIR  : ST_SHIR;
				ST_UPIR:  next_st.tap = tms_s ? ST_SELDR : ST_IDLE;
				default:  next_st.tap = ST_RESET;
			endcase
			// Register actions in the state being left
			unique case (st.tap)
				ST_CAPIR: next_st.ir_sh = 3'h1;
				ST_SHIR:  next_st.ir_sh = {tdi_s, st.ir_sh[IR_W-1:1]};
				// Any loaded code is accepted as is
				ST_UPIR:  next_st.ir = st.ir_sh;
				ST_CAPDR: begin
					next_st.byp   = 1'b0;
					next_st.id_sh = id_val;
					next_st.bs_sh = ring_mix;
				end
				ST_SHDR: begin
					next_st.byp   = tdi_s;
					next_st.id_sh = {tdi_s, st.id_sh[ID_W-1:1]};
					next_st.bs_sh = {tdi_s, st.bs_sh[CHAIN_N-1:1]};
				end
				ST_UPDR: begin
					if (st.ir == OP_EXT || st.ir == OP_SAMPLE) begin
						next_st.bs_up = st.bs_sh;
					end
				end
				default: begin
				end
			endcase
		end
		if (st.tap == ST_RESET) begin
			next_st.ir = IR_RST;
			next_st.bs_up[OE_CELL] = OE_RST;
		end
		// Output changes on falling edge only
		if (fall) begin
			next_st.tdo = sdo;
			next_st.tdo_oe_b = ~(st.tap == ST_SHDR || st.tap == ST_SHIR);
		end
		next_st.ext = (next_st.ir == OP_EXT);
		// Float on sample-float, or on low enable cell under external test
		next_st.flt = (next_st.ir == OP_SNAPZ) ||
			((next_st.ir == OP_EXT) && !next_st.bs_up[OE_CELL]);
		if (!rst_b_in) begin
			next_st = '0;
			next_st.tap = ST_RESET;
			next_st.ir = IR_RST;
			next_st.tdo_oe_b = 1'b1;
			next_st.bs_up[OE_CELL] = OE_RST;
		end
	end

	// Register the whole state
	always_ff @(posedge mclk_in) begin
		st <= next_st;
	end

	assign tdo_out      = st.tdo;
	assign tdo_oe_b_out = st.tdo_oe_b;
	assign pins_drv_out = st.bs_up;
	assign ext_mode_out = st.ext;
	assign q_float_out  = st.flt;
	assign ir_out       = st.ir;

	// Reset state forces identification next cycle
	reset_ident_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		st.tap == ST_RESET |=> st.ir == OP_IDENT)
		else $error("instruction not identification after reset state");
	// Output only moves after falling edge
	tdo_fall_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		$changed(tdo_out) |-> $past(fall))
		else $error("serial output changed without falling edge");
	snap_float_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		st.ir == OP_SNAPZ |-> q_float_out)
		else $error("outputs not floated in sample-float");
	// Low enable cell floats under external test
	oe_cell_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		(st.ir == OP_EXT) && !st.bs_up[OE_CELL] |-> q_float_out)
		else $error("enable cell low but outputs driven");
	// Enable latch high in reset state
	oe_preset_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		st.tap == ST_RESET |=> st.bs_up[OE_CELL])
		else $error("enable latch not preset");
	// Rising edge with mode high leaves idle to select
	tap_walk_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rise && tms_s && st.tap == ST_IDLE |=> st.tap == ST_SELDR)
		else $error("controller step wrong");
	byp_cap_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rise && st.tap == ST_CAPDR |=> st.byp == 1'b0)
		else $error("bypass capture not zero");
	id_cap_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rise && st.tap == ST_CAPDR |=> st.id_sh[0] == 1'b1)
		else $error("identification bit 0 not one");
	ext_mode_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		st.ir == OP_EXT |-> ext_mode_out)
		else $error("external mode not driven");
	ir_cap_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rise && st.tap == ST_CAPIR |=> st.ir_sh == 3'h1)
		else $error("instruction capture pattern wrong");
	ir_shift_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rise && st.tap == ST_SHIR |=> st.ir_sh == {$past(tdi_s), $past(st.ir_sh[IR_W-1:1])})
		else $error("instruction shift wrong");
	// Update takes shifted code as is
	ir_upd_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rise && st.tap == ST_UPIR |=> st.ir == $past(st.ir_sh))
		else $error("instruction update wrong");
	bs_cap_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rise && st.tap == ST_CAPDR |=> st.bs_sh == $past(ring_mix))
		else $error("boundary capture wrong");
	id_out_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		fall && st.ir == OP_IDENT && st.tap == ST_SHDR |=> tdo_out == $past(st.id_sh[0]))
		else $error("identification bit not on serial output");
	byp_out_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		fall && st.ir == OP_BYPASS && st.tap == ST_SHDR |=> tdo_out == $past(st.byp))
		else $error("bypass bit not on serial output");
	sample_quiet_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		st.ir == OP_SAMPLE |-> !ext_mode_out && !q_float_out)
		else $error("sample/preload disturbs memory outputs");
	// Update latches preload under external test
	ext_latch_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rise && st.tap == ST_UPDR && st.ir == OP_EXT |=> pins_drv_out == $past(st.bs_sh))
		else $error("preload not latched under external test");
	tdo_drive_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		fall && st.tap == ST_SHDR |=> !tdo_oe_b_out)
		else $error("serial output not driven in shift");
	tdo_park_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		fall && st.tap == ST_IDLE |=> tdo_oe_b_out)
		else $error("serial output driven in idle");
	// Mode high in select-IR reaches reset
	tap_exit_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		rise && tms_s && st.tap == ST_SELIR |=> st.tap == ST_RESET)
		else $error("controller did not reach reset state");
	id_word_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		id_val == {ID_VERSION, ID_PART, ID_MAKER, ID_PRESENT})
		else $error("identification word layout wrong");
	// Reset state leaves no external mode
	tlr_quiet_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		st.tap == ST_RESET |=> !ext_mode_out)
		else $error("external mode left on in reset state");
endmodule

// *** sbst_jtag_ctl.sv ***
// Test controller model that drives the scan pins
module sbst_jtag_ctl (
	input  wire logic mclk_in,  // Time base only
	input  wire logic tdo_in,   // Serial data from the port
	output logic      tck_out,  // Test clock, still between frames
	output logic      tms_out,  // Mode select, high at time zero, low after each frame
	output logic      tdi_out   // Serial data, idles high
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle levels at time zero
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b1;
	end
	// One 400 ns test cycle, tdo taken at the rise
	task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
		@(negedge mclk_in);
		tck_out = 1'b0;
		tms_out = tms_v;
		tdi_out = tdi_v;
		repeat (4) @(negedge mclk_in);
		tdo_v = tdo_in;
		tck_out = 1'b1;
		repeat (3) @(negedge mclk_in);
	endtask
	// Five ones reach reset state, then park in idle
	task automatic to_reset();
		logic d;
		repeat (5) step(1'b1, 1'b1, d);
		step(1'b0, 1'b1, d);
	endtask
	// Scan from idle through capture, shift, update back to idle
	task automatic scan(input logic ir_v, input int n, input logic [127:0] din,
		output logic [127:0] dout);
		logic d;
		dout = '0;
		step(1'b1, 1'b1, d);
		if (ir_v) begin
			step(1'b1, 1'b1, d);
		end
		step(1'b0, 1'b1, d);
		step(1'b0, 1'b1, d);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], d);
			dout[i] = d;
		end
		step(1'b1, 1'b1, d);
		step(1'b0, 1'b1, d);
	endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the boundary-scan test port
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import sbst_pkg::*;
	logic             mclk;      // Block clock
	logic             rst_b;     // Reset, low
	logic             tck;       // Test clock
	logic             tms;       // Mode select
	logic             tdi;       // Serial in
	logic             tdo;       // Serial out
	logic             tdo_oe_b;  // Serial out enable, low
	logic [BSC_N-1:0] pins;      // Pin ring values
	logic [BSC_N-1:0] pins_drv;  // Latched preload values
	logic [BSC_N-1:0] pre;       // Preload pattern
	logic [BSC_N-1:0] e;         // Expected capture
	logic             ext_mode;  // Test values on pins
	logic             q_float;   // Outputs floated
	logic [IR_W-1:0]  ir;        // Active instruction
	logic [127:0]     got;       // Shifted-out data
	int               n_fail;    // Mismatches
	int               n_tests;   // Comparisons
	// Block clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	sbst_tap u_sbst_tap (.mclk_in(mclk), .rst_b_in(rst_b), .tck_in(tck), .tms_in(tms),
		.tdi_in(tdi), .tdo_out(tdo), .tdo_oe_b_out(tdo_oe_b), .pins_in(pins),
		.pins_drv_out(pins_drv), .ext_mode_out(ext_mode), .q_float_out(q_float),
		.ir_out(ir));
	sbst_jtag_ctl u_sbst_jtag_ctl (.mclk_in(mclk), .tdo_in(tdo), .tck_out(tck),
		.tms_out(tms), .tdi_out(tdi));
	// Compare and count
	task automatic chk(input logic [127:0] g, input logic [127:0] x);
		n_tests++;
		if (g !== x) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// Verdict and end of run
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Load an instruction, checking the fixed capture value
	// Only defined codes are ever loaded
	task automatic ir_load(input logic [2:0] c);
		u_sbst_jtag_ctl.scan(1'b1, IR_W, {125'h0, c}, got);
		chk(got[2:0], 3'h1);
		chk(ir, c);
	endtask
	// Identification after reset
	task automatic t_id();
		chk(ir, OP_IDENT);
		chk(pins_drv, BSC_N'(1) << OE_CELL);
		chk({tdo_oe_b, ext_mode, q_float}, 3'h4);
		u_sbst_jtag_ctl.to_reset();
		u_sbst_jtag_ctl.scan(1'b0, ID_W + 1, '0, got);
		chk(got[32:0], {1'b0, ID_VERSION, ID_PART, ID_MAKER, 1'b1});
	endtask
	// Single-bit bypass path
	task automatic t_bypass();
		ir_load(OP_BYPASS);
		u_sbst_jtag_ctl.scan(1'b0, 4, 128'hb, got);
		chk(got[3:0], 4'h6);
	endtask
	// Sample and preload, no effect on pins
	task automatic t_sample();
		ir_load(OP_SAMPLE);
		e = pins;
		e[OE_CELL] = 1'b1;
		u_sbst_jtag_ctl.scan(1'b0, BSC_N, 128'(pre), got);
		chk(got[BSC_N-1:0], e);
		chk(pins_drv, pre);
		chk({ext_mode, q_float}, 2'h0);
	endtask
	// External test drives preload, cell 47 controls float
	task automatic t_extest();
		ir_load(OP_EXT);
		chk({ext_mode, q_float}, 2'h3);
		chk(pins_drv, pre);
		e = pins;
		e[OE_CELL] = 1'b0;
		u_sbst_jtag_ctl.scan(1'b0, BSC_N, 128'(~pre), got);
		chk(got[BSC_N-1:0], e);
		chk({ext_mode, q_float}, 2'h2);
		chk(pins_drv, BSC_N'(~pre));
	endtask
	// Snapshot with floated outputs
	task automatic t_snapz();
		pins = ~pins;
		ir_load(OP_SNAPZ);
		chk({ext_mode, q_float}, 2'h1);
		e = pins;
		e[OE_CELL] = 1'b1;
		u_sbst_jtag_ctl.scan(1'b0, BSC_N, 128'(pre), got);
		chk(got[BSC_N-1:0], e);
		chk(pins_drv, BSC_N'(~pre));
	endtask
	// Reset state from the pins restores identification and the enable latch
	task automatic t_tlr();
		ir_load(OP_SAMPLE);
		e = pins;
		e[OE_CELL] = 1'b1;
		u_sbst_jtag_ctl.scan(1'b0, BSC_N, 128'(pre), got);
		chk(got[BSC_N-1:0], e);
		chk(pins_drv[OE_CELL], 1'b0);
		u_sbst_jtag_ctl.to_reset();
		chk(ir, OP_IDENT);
		chk({pins_drv[OE_CELL], ext_mode, q_float}, 3'h4);
	endtask
	// Main sequence
	initial begin
		n_fail = 0;
		n_tests = 0;
		rst_b = 1'b0;
		pins = BSC_N'({4{32'hc3a5_5a3c}});
		pre = BSC_N'({4{32'h0f1e_2d4b}});
		pre[OE_CELL] = 1'b0;
		repeat (4) @(negedge mclk);
		rst_b = 1'b1;
		t_id();
		t_bypass();
		t_sample();
		t_extest();
		t_snapz();
		t_tlr();
		report_and_stop();
	end
	// Watchdog, well beyond the expected run
	initial begin
		#2000000;
		n_fail++;
		report_and_stop();
	end
endmodule
